// *** hdl/rtsf_pkg.sv ***
package rtsf_pkg;

	// session flag choices
	typedef enum logic [1:0] {
		RTSF_SESSION_ALL_TAGS           = 2'h0,
		RTSF_SESSION_TIMED_REFRESH      = 2'h1,
		RTSF_SESSION_ABSENT_REFRESH     = 2'h2,
		RTSF_SESSION_ALT_ABSENT_REFRESH = 2'h3
	} rtsf_session_t;

	// filter combining options
	typedef enum logic [1:0] {
		RTSF_FILT_FIRST  = 2'h0,
		RTSF_FILT_SECOND = 2'h1,
		RTSF_FILT_AND    = 2'h2,
		RTSF_FILT_OR     = 2'h3
	} rtsf_filt_mode_t;

	// tag memory bank codes
	localparam logic [1:0] RTSF_BANK_PASSWORDS = 2'h0;
	localparam logic [1:0] RTSF_BANK_EPC       = 2'h1;
	localparam logic [1:0] RTSF_BANK_TAG_ID    = 2'h2;
	localparam logic [1:0] RTSF_BANK_USER      = 2'h3;

	// factory defaults per access mode
	localparam rtsf_session_t RTSF_DEFAULT_ONCE_SESSION   = RTSF_SESSION_ALL_TAGS;
	localparam rtsf_session_t RTSF_DEFAULT_REPEAT_SESSION = RTSF_SESSION_ABSENT_REFRESH;

	// memory geometry
	localparam int RTSF_WORD_BITS   = 16;
	localparam int RTSF_EPC_WORDS   = 8;
	localparam int RTSF_EPC_BITS    = RTSF_WORD_BITS * RTSF_EPC_WORDS;
	localparam int RTSF_EPC_ID_BITS = 96;
	localparam int RTSF_ADDR_BITS   = 7;
	localparam int RTSF_LEN_BITS    = 8;
	localparam int RTSF_TABLE_DEPTH = 16;
	localparam int RTSF_IDX_BITS    = 4;

	// epc bank word positions (word 0 at the top bits)
	localparam int RTSF_EPC_CRC_WORD   = 0;
	localparam int RTSF_EPC_PROTO_WORD = 1;
	localparam int RTSF_EPC_ID_WORD    = 2;

	// session states
	typedef enum logic [3:0] {
		RTSF_ST_IDLE   = 4'h1,
		RTSF_ST_RUN    = 4'h2,
		RTSF_ST_REPORT = 4'h4,
		RTSF_ST_DONE   = 4'h8
	} rtsf_state_t;

endpackage

// *** hdl/rtsf_session_filter.sv ***
`timescale 1ns/100ps
`default_nettype none
// Operation
// - default session: all tags for once, absent refresh for repeat commands
// - once mode with all tags: every tag in field is communicated with
// - once mode with other sessions: only unread tags, read ones skipped
// - repeat mode absent refresh: newly detected tags are communicated with
// - repeat mode all tags: reads tags left in conflicting flag state
// - repeat mode alt absent refresh behaves exactly like absent refresh
// - two filter conditions: bank, start address, bit length, data value
// - accept by first, second, AND or OR of the two conditions
// - duplicate suppression: each tag identifier at most once per response while its entry stays in the 16-entry id table
// - reread prevention in repeat modes: read tags not reported again while still held in the 16-entry id table
// - empty omission in repeat modes: no response for an empty period
// - bank codes: 00 passwords, 01 epc, 10 tag identification, 11 user
// - tag identification bank is read-only; never issue writes to it
// - multi repeat: report each period then continue until termination
module rtsf_session_filter
	import rtsf_pkg::*;
(
	input  wire logic                      core_clk_in,
	input  wire logic                      sys_rst_in,
	// command control
	input  wire logic                      cmd_start_in,
	input  wire logic                      cmd_stop_in,
	input  wire logic                      cmd_repeat_in,
	input  wire logic                      cmd_multi_in,
	input  wire logic                      session_override_in,
	input  wire logic [1:0]                session_sel_in,
	input  wire logic                      period_end_in,
	// smoothing options
	input  wire logic                      dup_suppress_in,
	input  wire logic                      reread_prevent_in,
	input  wire logic                      empty_omit_in,
	// filter conditions
	input  wire logic [1:0]                filt_mode_in,
	input  wire logic [1:0]                filt_bank_in     [2],
	input  wire logic [RTSF_ADDR_BITS-1:0] filt_addr_in     [2],
	input  wire logic [RTSF_LEN_BITS-1:0]  filt_len_in      [2],
	input  wire logic [RTSF_EPC_BITS-1:0]  filt_data_in     [2],
	// tag observed in field: whole epc bank, plus other bank images
	input  wire logic                      tag_valid_in,
	input  wire logic [RTSF_EPC_BITS-1:0]  tag_epc_bank_in,
	input  wire logic [RTSF_EPC_BITS-1:0]  tag_ident_bank_in,
	input  wire logic [RTSF_EPC_BITS-1:0]  tag_user_bank_in,
	input  wire logic [RTSF_EPC_BITS-1:0]  tag_pwd_bank_in,
	// write request gate
	input  wire logic                      wr_req_in,
	input  wire logic [1:0]                wr_bank_in,
	output logic                           wr_grant_out,
	// session flag sent to the air interface, and command busy status
	output logic [1:0]                     session_out,
	output logic                           busy_out,
	// report stream
	output logic                           rpt_valid_out,
	output logic [RTSF_EPC_ID_BITS-1:0]    rpt_epc_out,
	output logic [15:0]                    rpt_proto_ctl_out,
	output logic                           rsp_end_out,
	output logic [RTSF_IDX_BITS:0]         rsp_count_out
);

	rtsf_state_t state;
	rtsf_state_t next_state;
	logic        repeat_mode;
	logic        next_repeat_mode;
	logic        multi_mode;
	logic        next_multi_mode;
	logic        term_seen;
	logic        next_term_seen;
	logic [1:0]  session;
	logic [1:0]  next_session;
	logic [RTSF_EPC_ID_BITS-1:0] seen_id    [RTSF_TABLE_DEPTH];
	logic [RTSF_TABLE_DEPTH-1:0] seen_vld;    // read this command
	logic [RTSF_TABLE_DEPTH-1:0] seen_rsp;    // reported in this response
	logic [RTSF_TABLE_DEPTH-1:0] next_seen_vld;
	logic [RTSF_TABLE_DEPTH-1:0] next_seen_rsp;
	logic [RTSF_IDX_BITS-1:0]    wr_ptr;
	logic [RTSF_IDX_BITS-1:0]    next_wr_ptr;
	logic [RTSF_IDX_BITS:0]      count;
	logic [RTSF_IDX_BITS:0]      next_count;
	logic                        next_rpt_valid;
	logic [RTSF_EPC_ID_BITS-1:0] next_rpt_epc;
	logic [15:0]                 next_rpt_proto_ctl;
	logic                        next_rsp_end;
	logic [RTSF_IDX_BITS:0]      next_rsp_count;

	// pick the bank image addressed by a two-bit bank code
	function automatic logic [RTSF_EPC_BITS-1:0] bank_image(input logic [1:0] bank);
		case (bank)
			RTSF_BANK_PASSWORDS: bank_image = tag_pwd_bank_in;
			RTSF_BANK_EPC:       bank_image = tag_epc_bank_in;
			RTSF_BANK_TAG_ID:    bank_image = tag_ident_bank_in;
			default:             bank_image = tag_user_bank_in;
		endcase
	endfunction

	// compare len bits from bit address addr (bit 0 is msb of word 0)
	function automatic logic cond_match(input logic [1:0] bank,
			input logic [RTSF_ADDR_BITS-1:0] addr, input logic [RTSF_LEN_BITS-1:0] len,
			input logic [RTSF_EPC_BITS-1:0] data);
		logic [RTSF_EPC_BITS-1:0] img;
		logic [RTSF_EPC_BITS-1:0] shifted;
		logic [RTSF_EPC_BITS-1:0] mask;
		img = bank_image(bank);
		shifted = img << addr;
		mask = (len >= RTSF_LEN_BITS'(RTSF_EPC_BITS)) ? '1 :
			~({RTSF_EPC_BITS{1'b1}} >> len);
		// data is left-aligned in filt_data, same as shifted image
		cond_match = ((shifted ^ data) & mask) == '0;
	endfunction

	logic [1:0]                  hit;
	logic                        accept;
	logic [RTSF_EPC_ID_BITS-1:0] tag_id;
	logic [RTSF_TABLE_DEPTH-1:0] id_hit;
	logic                        known;
	logic                        known_rsp;
	logic [RTSF_IDX_BITS-1:0]    hit_idx;

	// per-entry id lookup
	genvar gi;
	generate
		for (gi = 0; gi < RTSF_TABLE_DEPTH; gi++) begin : g_cmp
			assign id_hit[gi] = seen_vld[gi] && (seen_id[gi] == tag_id);
		end
	endgenerate

	// filter combine and identity extraction
	always_comb begin
		hit[0] = cond_match(filt_bank_in[0], filt_addr_in[0], filt_len_in[0], filt_data_in[0]);
		hit[1] = cond_match(filt_bank_in[1], filt_addr_in[1], filt_len_in[1], filt_data_in[1]);
		case (rtsf_filt_mode_t'(filt_mode_in))
			RTSF_FILT_FIRST:  accept = hit[0];
			RTSF_FILT_SECOND: accept = hit[1];
			RTSF_FILT_AND:    accept = hit[0] & hit[1];
			default:          accept = hit[0] | hit[1];
		endcase
		// word 0 crc, word 1 protocol control, words 2..7 epc msw first
		tag_id = tag_epc_bank_in[RTSF_EPC_ID_BITS-1:0];
		known = |id_hit;
		known_rsp = |(id_hit & seen_rsp);
		// entry of a re-sighted id, so its response mark lands on that entry
		hit_idx = '0;
		for (int e = 0; e < RTSF_TABLE_DEPTH; e++) begin
			if (id_hit[e])
				hit_idx = RTSF_IDX_BITS'(e);
		end
	end

	// write gate: tag identification bank is never written
	assign wr_grant_out = wr_req_in && (wr_bank_in != RTSF_BANK_TAG_ID);
	assign session_out = session;
	assign busy_out = (state == RTSF_ST_RUN) || (state == RTSF_ST_REPORT);

	// session control and report next-state logic
	always_comb begin
		logic report_ok;
		logic sel_default;
		report_ok = 1'b0;
		sel_default = 1'b0;
		next_state = state;
		next_repeat_mode = repeat_mode;
		next_multi_mode = multi_mode;
		next_session = session;
		next_term_seen = term_seen;
		next_seen_vld = seen_vld;
		next_seen_rsp = seen_rsp;
		next_wr_ptr = wr_ptr;
		next_count = count;
		next_rpt_valid = 1'b0;
		next_rpt_epc = rpt_epc_out;
		next_rpt_proto_ctl = rpt_proto_ctl_out;
		next_rsp_end = 1'b0;
		next_rsp_count = rsp_count_out;
		case (state)
			RTSF_ST_IDLE, RTSF_ST_DONE: begin
				next_state = RTSF_ST_IDLE;
				if (cmd_start_in) begin
					sel_default = !session_override_in;
					next_repeat_mode = cmd_repeat_in;
					next_multi_mode = cmd_multi_in;
					if (sel_default)
						next_session = cmd_repeat_in ? RTSF_DEFAULT_REPEAT_SESSION
							: RTSF_DEFAULT_ONCE_SESSION;
					else
						next_session = session_sel_in;
					next_seen_vld = '0;
					next_seen_rsp = '0;
					next_wr_ptr = '0;
					next_term_seen = 1'b0;
					next_count = '0;
					next_state = RTSF_ST_RUN;
				end
			end
			RTSF_ST_RUN: begin
				if (tag_valid_in && accept) begin
					// once with all tags: report each tag seen; other once sessions or reread prevention: skip read ones
					if (!repeat_mode && session == RTSF_SESSION_ALL_TAGS)
						report_ok = !(dup_suppress_in && known_rsp);
					else if (!repeat_mode)
						report_ok = !known;
					else if (reread_prevent_in)
						report_ok = !known;
					else
						report_ok = !(dup_suppress_in && known_rsp);
					if (report_ok) begin
						next_rpt_valid = 1'b1;
						next_rpt_epc = tag_id;
						next_rpt_proto_ctl = tag_epc_bank_in[RTSF_EPC_BITS-RTSF_WORD_BITS*RTSF_EPC_PROTO_WORD-1
							-: RTSF_WORD_BITS];
						next_count = count + 1'b1;
						if (!known) begin
							next_seen_vld[wr_ptr] = 1'b1;
							next_wr_ptr = wr_ptr + 1'b1; // oldest entry overwritten when full
						end
						next_seen_rsp[known ? hit_idx : wr_ptr] = 1'b1;
					end
				end
				// single mode ends a transaction at its first reported tag
				if (cmd_stop_in || period_end_in || (!multi_mode && report_ok))
					next_state = RTSF_ST_REPORT;
			end
			RTSF_ST_REPORT: begin
				next_rsp_count = count;
				// repeat modes may drop an empty response
				next_rsp_end = !(repeat_mode && empty_omit_in && count == '0);
				next_count = '0;
				next_seen_rsp = '0;
				if (repeat_mode && !cmd_stop_in && !term_seen)
					next_state = RTSF_ST_RUN;
				else
					next_state = RTSF_ST_DONE;
			end
			default: next_state = RTSF_ST_IDLE;
		endcase
		// remembered apart from the mode, so repeat still ends after the report once stop has dropped
		if (cmd_stop_in && state == RTSF_ST_RUN)
			next_term_seen = 1'b1; // termination ends repeat after this report
	end

	// state registers; seen table holds ids only, no reset needed
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			state <= RTSF_ST_IDLE;
			repeat_mode <= 1'b0;
			multi_mode <= 1'b0;
			term_seen <= 1'b0;
			session <= RTSF_DEFAULT_ONCE_SESSION;
			seen_vld <= '0;
			seen_rsp <= '0;
			wr_ptr <= '0;
			count <= '0;
			rpt_valid_out <= 1'b0;
			rpt_epc_out <= '0;
			rpt_proto_ctl_out <= 16'h0000;
			rsp_end_out <= 1'b0;
			rsp_count_out <= '0;
		end else begin
			state <= next_state;
			repeat_mode <= next_repeat_mode;
			multi_mode <= next_multi_mode;
			term_seen <= next_term_seen;
			session <= next_session;
			seen_vld <= next_seen_vld;
			seen_rsp <= next_seen_rsp;
			wr_ptr <= next_wr_ptr;
			count <= next_count;
			rpt_valid_out <= next_rpt_valid;
			rpt_epc_out <= next_rpt_epc;
			rpt_proto_ctl_out <= next_rpt_proto_ctl;
			rsp_end_out <= next_rsp_end;
			rsp_count_out <= next_rsp_count;
		end
	end

	// id table write; an id is recorded in the cycle its report goes out
	always_ff @(posedge core_clk_in) begin
		if (state == RTSF_ST_RUN && next_rpt_valid && !known)
			seen_id[wr_ptr] <= tag_id;
	end

endmodule
`default_nettype wire

// *** verification/rtsf_session_filter_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
// port-level checks for the session filter
module rtsf_session_filter_asserts
	import rtsf_pkg::*;
(
	input wire logic                          core_clk_in,
	input wire logic                          sys_rst_in,
	input wire logic                          cmd_stop_in,
	input wire logic                          cmd_repeat_in,
	input wire logic                          session_override_in,
	input wire logic [1:0]                    session_sel_in,
	input wire logic                          tag_valid_in,
	input wire logic [RTSF_EPC_BITS-1:0]      tag_epc_bank_in,
	input wire logic                          wr_req_in,
	input wire logic [1:0]                    wr_bank_in,
	input wire logic                          wr_grant_out,
	input wire logic [1:0]                    session_out,
	input wire logic                          busy_out,
	input wire logic                          rpt_valid_out,
	input wire logic [RTSF_EPC_ID_BITS-1:0]   rpt_epc_out,
	input wire logic [15:0]                   rpt_proto_ctl_out,
	input wire logic                          rsp_end_out,
	input wire logic [RTSF_IDX_BITS:0]        rsp_count_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	// reset is watched while it is held, so it opts out of the default disable
	a_reset_quiet: assert property (disable iff (1'b0) sys_rst_in |=>
		!busy_out && !rpt_valid_out && !rsp_end_out && session_out == 2'h0)
		else $error("outputs not cleared by reset");
	a_ident_no_write: assert property (wr_grant_out == (wr_req_in && wr_bank_in != 2'h2))
		else $error("write grant wrong");
	// session is latched at the start edge
	a_once_default: assert property ($rose(busy_out) && !$past(session_override_in)
		&& !$past(cmd_repeat_in) |-> session_out == 2'h0) else $error("once default wrong");
	a_repeat_default: assert property ($rose(busy_out) && !$past(session_override_in)
		&& $past(cmd_repeat_in) |-> session_out == 2'h2) else $error("repeat default wrong");
	a_session_chosen: assert property ($rose(busy_out) && $past(session_override_in)
		|-> session_out == $past(session_sel_in)) else $error("chosen session wrong");
	a_report_data: assert property (rpt_valid_out |-> $past(tag_valid_in) && $past(busy_out)
		&& rpt_proto_ctl_out == $past(tag_epc_bank_in[111:96])
		&& rpt_epc_out == $past(tag_epc_bank_in[95:0])) else $error("report data wrong");
	a_stop_ends: assert property (cmd_stop_in && busy_out |-> ##[1:6] !busy_out)
		else $error("stop ignored");
	a_end_single: assert property (rsp_end_out |=> !rsp_end_out)
		else $error("response end not a pulse");
	c_start: cover property ($rose(busy_out));
	c_report: cover property (rpt_valid_out);
	c_empty: cover property (rsp_end_out && rsp_count_out == 5'h0);
endmodule
`default_nettype wire

// *** verification/rtsf_session_filter_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module rtsf_session_filter_tb_top
	import rtsf_pkg::*;
;
	logic clk = 0, rst = 1, st = 0, sp = 0, rep = 0, mul = 0, ovr = 0, pe = 0, tv;
	logic dup = 0, rrp = 0, eom = 0, wrq = 0, show = 0, m0 = 0, m1 = 0, gr, bsy, rv, re;
	logic [1:0] sel = 0, fm = 0, wb = 0, so, fb [2];
	logic [7:0] id = 0, fl [2];
	logic [6:0] fa [2];
	logic [127:0] fd [2], eb, ub, ib, pb;
	logic [95:0] epc;
	logic [15:0] proto;
	logic [4:0] cnt, last_cnt;
	int errors = 0, n_compared = 0, n_rpt = 0, n_end = 0;
	// {mode, first matches, second matches, reported}
	logic [4:0] rows [8] = '{5'h05, 5'h02, 5'h0b, 5'h0c, 5'h14, 5'h17, 5'h1b, 5'h18};
	// {override, session, dup suppress, count}
	logic [5:0] dd [3] = '{6'h29, 6'h02, 6'h05};
	always #2 clk = ~clk;
	rtsf_tag_field u_rtsf_tag_field (.core_clk_in(clk), .show_in(show), .id_in(id),
		.m0_in(m0), .m1_in(m1), .tag_valid_out(tv), .epc_bank_out(eb),
		.user_bank_out(ub), .ident_bank_out(ib), .pwd_bank_out(pb));
	rtsf_session_filter u_rtsf_session_filter (.core_clk_in(clk), .sys_rst_in(rst),
		.cmd_start_in(st), .cmd_stop_in(sp), .cmd_repeat_in(rep), .cmd_multi_in(mul),
		.session_override_in(ovr), .session_sel_in(sel), .period_end_in(pe),
		.dup_suppress_in(dup), .reread_prevent_in(rrp), .empty_omit_in(eom),
		.filt_mode_in(fm), .filt_bank_in(fb), .filt_addr_in(fa), .filt_len_in(fl),
		.filt_data_in(fd), .tag_valid_in(tv), .tag_epc_bank_in(eb), .tag_ident_bank_in(ib),
		.tag_user_bank_in(ub), .tag_pwd_bank_in(pb), .wr_req_in(wrq), .wr_bank_in(wb),
		.wr_grant_out(gr), .session_out(so), .busy_out(bsy), .rpt_valid_out(rv),
		.rpt_epc_out(epc), .rpt_proto_ctl_out(proto), .rsp_end_out(re), .rsp_count_out(cnt));
	// tally report pulses and response ends
	always @(posedge clk) begin
		if (rv)
			n_rpt++;
		if (re) begin
			n_end++;
			last_cnt = cnt;
		end
	end
	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	// counters cleared off the edge to avoid racing the tally
	task automatic go(input logic r, input logic o, input logic [1:0] s);
		@(negedge clk);
		n_rpt = 0;
		n_end = 0;
		@(posedge clk);
		st <= 1'b1;
		rep <= r;
		ovr <= o;
		sel <= s;
		@(posedge clk);
		st <= 1'b0;
		#1;
	endtask
	task automatic tg(input logic [7:0] i, input logic a, input logic b);
		@(posedge clk);
		show <= 1'b1;
		id <= i;
		m0 <= a;
		m1 <= b;
		@(posedge clk);
		show <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	// close a period, or stop the command
	task automatic fin(input logic s);
		@(posedge clk);
		sp <= s;
		pe <= !s;
		@(posedge clk);
		sp <= 1'b0;
		pe <= 1'b0;
		repeat (5) @(posedge clk);
		#1;
	endtask
	task automatic stop_test();
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#20000;
		errors++;
		stop_test();
	end
	initial begin
		// first: epc word 2 is abcd; second: first user byte is 5a
		@(posedge clk);
		fb <= '{RTSF_BANK_EPC, RTSF_BANK_USER};
		fa <= '{7'h20, 7'h00};
		fl <= '{8'h10, 8'h08};
		fd <= '{{16'habcd, 112'h0}, {8'h5a, 120'h0}};
		mul <= 1'b1;
		repeat (11) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk({bsy, rv, re, so}, 5'h0);
		foreach (rows[k]) begin
			@(posedge clk);
			fm <= rows[k][4:3];
			go(1'b0, 1'b0, 2'h0);
			chk(so, RTSF_SESSION_ALL_TAGS);
			tg(8'h10 + 8'(k), rows[k][2], rows[k][1]);
			fin(1'b0);
			chk(n_rpt, rows[k][0]);
			chk({bsy, last_cnt}, {1'b0, 4'h0, rows[k][0]});
			// the tag model's banks: protocol control 3000, epc word 2 set by m0
			if (rows[k][0])
				chk({proto, epc},
					{16'h3000, rows[k][2] ? 16'habcd : 16'h0000, 72'h0, 8'h10 + 8'(k)});
		end
		foreach (dd[k]) begin
			@(posedge clk);
			fm <= RTSF_FILT_FIRST;
			dup <= dd[k][2];
			go(1'b0, dd[k][5], dd[k][4:3]);
			tg(8'h40, 1'b1, 1'b0);
			tg(8'h40, 1'b1, 1'b0);
			fin(1'b0);
			chk(last_cnt, dd[k][1:0]);
		end
		for (int b = 0; b < 4; b++) begin
			@(posedge clk);
			wrq <= 1'b1;
			wb <= 2'(b);
			#1;
			chk(gr, b != 2);
		end
		go(1'b1, 1'b0, 2'h0);
		chk(so, RTSF_SESSION_ABSENT_REFRESH);
		tg(8'h48, 1'b1, 1'b0);
		fin(1'b0);
		chk(last_cnt, 5'h1);
		// same tag twice in the next period: one report per response
		tg(8'h48, 1'b1, 1'b0);
		tg(8'h48, 1'b1, 1'b0);
		fin(1'b0);
		chk(last_cnt, 5'h1);
		fin(1'b1);
		chk(bsy, 1'b0);
		// repeated periods: reread blocked, empty period silent
		@(posedge clk);
		rrp <= 1'b1;
		eom <= 1'b1;
		go(1'b1, 1'b1, 2'h3);
		chk(so, RTSF_SESSION_ALT_ABSENT_REFRESH);
		tg(8'h50, 1'b1, 1'b0);
		fin(1'b0);
		tg(8'h50, 1'b1, 1'b0);
		tg(8'h51, 1'b1, 1'b0);
		fin(1'b0);
		chk(last_cnt, 5'h1);
		fin(1'b0);
		chk(n_end, 2);
		fin(1'b1);
		chk(n_end, 2);
		go(1'b1, 1'b1, 2'h0);
		chk(so, RTSF_SESSION_ALL_TAGS);
		tg(8'h60, 1'b1, 1'b0);
		fin(1'b1);
		chk({bsy, n_rpt[1:0]}, 3'h1);
		stop_test();
	end
endmodule
bind rtsf_session_filter rtsf_session_filter_asserts u_rtsf_session_filter_asserts (
	.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .cmd_stop_in(cmd_stop_in),
	.cmd_repeat_in(cmd_repeat_in), .session_override_in(session_override_in),
	.session_sel_in(session_sel_in), .tag_valid_in(tag_valid_in),
	.tag_epc_bank_in(tag_epc_bank_in), .wr_req_in(wr_req_in), .wr_bank_in(wr_bank_in),
	.wr_grant_out(wr_grant_out), .session_out(session_out), .busy_out(busy_out),
	.rpt_valid_out(rpt_valid_out), .rpt_epc_out(rpt_epc_out),
	.rpt_proto_ctl_out(rpt_proto_ctl_out),
	.rsp_end_out(rsp_end_out), .rsp_count_out(rsp_count_out));
`default_nettype wire

// *** verification/rtsf_tag_field.sv ***
`timescale 1ns/100ps
`default_nettype none
// tags in the field: one sighting per show pulse
module rtsf_tag_field
	import rtsf_pkg::*;
(
	input  wire logic                     core_clk_in,
	input  wire logic                     show_in,
	input  wire logic [7:0]               id_in,
	input  wire logic                     m0_in,
	input  wire logic                     m1_in,
	output logic                          tag_valid_out,
	output logic [RTSF_EPC_BITS-1:0]      epc_bank_out,
	output logic [RTSF_EPC_BITS-1:0]      user_bank_out,
	output logic [RTSF_EPC_BITS-1:0]      ident_bank_out,
	output logic [RTSF_EPC_BITS-1:0]      pwd_bank_out
);
	// tags stay energised, so no flag ever refreshes within a run
	// banks toggle between sightings so stale data never looks valid
	always_ff @(posedge core_clk_in) begin
		tag_valid_out <= show_in;
		if (show_in) begin
			// crc, protocol control, epc most significant word first
			epc_bank_out <= {16'h1234, 16'h3000, m0_in ? 16'habcd : 16'h0000, 72'h0, id_in};
			user_bank_out <= {m1_in ? 8'h5a : 8'ha5, 120'h0};
			ident_bank_out <= {8'h0f, 120'h0}; // arbitrary contents
			pwd_bank_out <= 128'h0;
		end else begin
			{epc_bank_out, user_bank_out, ident_bank_out, pwd_bank_out} <=
				~{epc_bank_out, user_bank_out, ident_bank_out, pwd_bank_out};
		end
	end
endmodule
`default_nettype wire
